/* File: verilog/dual_timer_map.svh */
// register offsets, field positions, reset values and timing counts of the timers
// assumes inclusion by bare name from the timer package and design files
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define ADDR_MODE      8'hf1
`define ADDR_CNT_ONE   8'hf2
`define ADDR_PSC_ONE   8'hf3
`define ADDR_CNT_ZERO  8'hf4
`define ADDR_PSC_ZERO  8'hf5
`define ADDR_STAT      8'he0
`define ADDR_MASK      8'he1
`define ADDR_CASC      8'he2

// ********************************************************************
// count mode register fields
// ********************************************************************
`define MODE_LD0       0
`define MODE_EN0       1
`define MODE_LD1       2
`define MODE_EN1       3
`define MODE_IN_LO     4
`define MODE_OUT_LO    6
`define MODE_WMASK     8'hfa
`define IN_CLOCK       2'b00
`define IN_GATE        2'b01
`define IN_TRIG_ONCE   2'b10
`define IN_TRIG_RE     2'b11
`define OUT_CNT_ZERO   2'b00
`define OUT_CNT_ONE    2'b01
`define OUT_CLK        2'b10

// ********************************************************************
// prescaler register fields
// ********************************************************************
`define PSC_CONT       0
`define PSC_SRC        1
`define PSC_VAL_LO     2

// ********************************************************************
// reset values and timing
// ********************************************************************
`define RST_BYTE       8'h00
`define CLK_NS         4
`define DIV_NS         16
`define DIV_CYC        (`DIV_NS / `CLK_NS)
`define DIV_LAST       2'(`DIV_CYC - 1)

`endif

/* File: verilog/dual_timer_pkg.sv */
// types shared by the timer top and the counter unit
// assumes the map header sits beside it on the include path
package dual_timer_pkg;
  `include "dual_timer_map.svh"

  typedef enum logic [1:0]
  {
    CNT_STOP = 2'b01,
    CNT_RUN  = 2'b10
  } cstate_t;

  typedef struct packed
  {
    cstate_t     st;
    logic [5:0]  pre;
    logic [7:0]  cnt;
    logic        eoc;
    logic        timer_output_pin;
  } cnt_state_t;

  typedef struct packed
  {
    logic [7:0]  mode;
    logic [7:0]  psc0;
    logic [7:0]  psc1;
    logic [7:0]  init0;
    logic [7:0]  init1;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic        casc;
    logic [7:0]  rdata;
    logic [1:0]  div;
    logic        ext_q;
    logic        line;
  } top_state_t;
endpackage

/* File: verilog/counter_if.sv */
// control and status bundle between the timer top and one counter unit
// assumes both ends share one clock
`timescale 1ns/1ps
interface counter_if;
  logic        tick;
  logic        load;
  logic        enable;
  logic        modulo;
  logic [5:0]  pre_val;
  logic [7:0]  init;
  logic [7:0]  count;
  logic        eoc;
  logic        timer_output_pin;
  logic        running;

  modport ctl (output tick, load, enable, modulo, pre_val, init,
               input  count, eoc, timer_output_pin, running);
  modport cnt (input  tick, load, enable, modulo, pre_val, init,
               output count, eoc, timer_output_pin, running);
endinterface

/* File: verilog/counter_unit.sv */
// one 8-bit down counter with a 6-bit prescaler
// assumes tick and load are one-cycle qualified by the top's clock enable
`timescale 1ns/1ps
module counter_unit
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  ce_i,
  // control bundle
  counter_if.cnt     port
);
  import dual_timer_pkg::*;

  cnt_state_t st_ff;
  cnt_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (ce_i)
    begin
      nxt_st.eoc = 1'b0;
      if (port.load)
      begin
        nxt_st.pre = port.pre_val;
        nxt_st.cnt = port.init;
        nxt_st.st  = CNT_RUN;
      end
      else
      begin
        case (st_ff.st)
          CNT_RUN:
          begin
            if (port.enable && port.tick)
            begin
              // prescale value zero divides by 64
              if (st_ff.pre != 6'h01)
              begin
                nxt_st.pre = st_ff.pre - 6'h01;
              end
              else
              begin
                nxt_st.pre = port.pre_val;
                if (st_ff.cnt == 8'h01)
                begin
                  nxt_st.eoc  = 1'b1;
                  nxt_st.timer_output_pin = ~st_ff.timer_output_pin;
                  if (port.modulo)
                  begin
                    nxt_st.cnt = port.init;
                  end
                  else
                  begin
                    nxt_st.cnt = 8'h00;
                    nxt_st.st  = CNT_STOP;
                  end
                end
                else
                begin
                  nxt_st.cnt = st_ff.cnt - 8'h01;
                end
              end
            end
          end
          CNT_STOP: nxt_st.st = CNT_STOP;
          default:  nxt_st.st = CNT_STOP;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '{st: CNT_STOP, pre: 6'h00, cnt: 8'h00, eoc: 1'b0, timer_output_pin: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign port.count   = st_ff.cnt;
  assign port.eoc     = st_ff.eoc;
  assign port.timer_output_pin    = st_ff.timer_output_pin;
  assign port.running = (st_ff.st == CNT_RUN);
endmodule

/* File: verilog/dual_timer.sv */
// dual 8-bit counter/timer with prescalers, input modes, output select, interrupts
// assumes register port strobes are one cycle and all inputs synchronous to mclk_i
//
// Summary of operation
// - single pass stops; continuous reloads and continues
// - counts readable undisturbed; prescalers read zero
// - second counter clocked by clock/4 or external
// - external input: clock, trigger, retrigger or gate
// - output line shows counter zero, one or clock
// - first counter end can clock second counter
// - count mode register at f1, read/write
// - second counter register at f2, read/write
// - each counter owns one maskable interrupt source
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module dual_timer
  import dual_timer_pkg::*;
(
  // clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // timer pins
  input  wire logic        ext_timer_input_line_i,
  output logic             timer_output_line_o,
  output logic             timer_output_line_oe_o,
  // interrupt
  output logic             irq_o
);
  import dual_timer_pkg::*;

  // ********************************************************************
  // state and counter bundles
  // ********************************************************************
  top_state_t  st_ff;
  top_state_t  nxt_st;
  counter_if   cif[2] ();

  logic        div_tick;
  logic        ext_rise;
  logic        src_int;
  logic [1:0]  in_mode;
  logic [1:0]  out_sel;
  logic        wr_mode;
  logic        trig_load;
  logic [1:0]  eoc_v;
  logic [1:0]  clr_v;
  logic        line_src;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_cnt
      counter_unit u_cnt
      (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .port      (cif[g])
      );
    end
  endgenerate

  // ********************************************************************
  // clocking of the two counters
  // ********************************************************************
  assign div_tick = (st_ff.div == `DIV_LAST);
  // input assumed synchronous, so one stage is enough for edge finding
  assign ext_rise = ext_timer_input_line_i & ~st_ff.ext_q;
  assign src_int  = st_ff.psc1[`PSC_SRC];
  assign in_mode  = st_ff.mode[`MODE_IN_LO +: 2];
  assign out_sel  = st_ff.mode[`MODE_OUT_LO +: 2];
  assign wr_mode  = ce_i && wr_i && (addr_i == `ADDR_MODE);

  // triggers restart the second counter only with the internal clock
  assign trig_load = ce_i && src_int && ext_rise &&
                     ((in_mode == `IN_TRIG_RE) ||
                      ((in_mode == `IN_TRIG_ONCE) && !cif[1].running));

  assign cif[0].tick    = div_tick;
  assign cif[0].load    = wr_mode && wdata_i[`MODE_LD0];
  assign cif[0].enable  = st_ff.mode[`MODE_EN0];
  assign cif[0].modulo  = st_ff.psc0[`PSC_CONT];
  assign cif[0].pre_val = st_ff.psc0[`PSC_VAL_LO +: 6];
  assign cif[0].init    = st_ff.init0;

  always_comb
  begin
    if (src_int)
    begin
      // gate mode qualifies the divided clock with the input level
      cif[1].tick = div_tick &&
                    ((in_mode != `IN_GATE) || ext_timer_input_line_i);
    end
    else if (st_ff.casc)
    begin
      cif[1].tick = cif[0].eoc;
    end
    else
    begin
      cif[1].tick = ext_rise;
    end
  end

  assign cif[1].load    = (wr_mode && wdata_i[`MODE_LD1]) || trig_load;
  assign cif[1].enable  = st_ff.mode[`MODE_EN1];
  assign cif[1].modulo  = st_ff.psc1[`PSC_CONT];
  assign cif[1].pre_val = st_ff.psc1[`PSC_VAL_LO +: 6];
  assign cif[1].init    = st_ff.init1;

  // ********************************************************************
  // events, output line source
  // ********************************************************************
  assign eoc_v = {cif[1].eoc, cif[0].eoc};
  assign clr_v = (wr_i && (addr_i == `ADDR_STAT)) ? wdata_i[1:0] : 2'h0;

  always_comb
  begin
    case (out_sel)
      `OUT_CNT_ZERO: line_src = cif[0].timer_output_pin;
      `OUT_CNT_ONE:  line_src = cif[1].timer_output_pin;
      `OUT_CLK:      line_src = st_ff.div[0];
      default:       line_src = 1'b0;
    endcase
  end

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    if (ce_i)
    begin
      nxt_st.rdata = 8'h00;
      nxt_st.div   = st_ff.div + 2'h1;
      nxt_st.ext_q = ext_timer_input_line_i;
      nxt_st.line  = line_src;
      // an event in the clearing cycle keeps its flag
      nxt_st.stat  = (st_ff.stat & ~clr_v) | eoc_v;
      if (wr_i)
      begin
        case (addr_i)
          `ADDR_MODE:     nxt_st.mode  = wdata_i & `MODE_WMASK;
          `ADDR_CNT_ONE:  nxt_st.init1 = wdata_i;
          `ADDR_PSC_ONE:  nxt_st.psc1  = wdata_i;
          `ADDR_CNT_ZERO: nxt_st.init0 = wdata_i;
          `ADDR_PSC_ZERO: nxt_st.psc0  = wdata_i;
          `ADDR_MASK:     nxt_st.mask  = wdata_i[1:0];
          `ADDR_CASC:     nxt_st.casc  = wdata_i[0];
          default:        nxt_st.casc  = st_ff.casc;
        endcase
      end
      if (rd_i)
      begin
        case (addr_i)
          `ADDR_MODE:     nxt_st.rdata = st_ff.mode;
          `ADDR_CNT_ONE:  nxt_st.rdata = cif[1].count;
          `ADDR_CNT_ZERO: nxt_st.rdata = cif[0].count;
          `ADDR_STAT:     nxt_st.rdata = {6'h00, st_ff.stat};
          `ADDR_MASK:     nxt_st.rdata = {6'h00, st_ff.mask};
          `ADDR_CASC:     nxt_st.rdata = {7'h00, st_ff.casc};
          // prescalers are write only and read back as zero
          default:        nxt_st.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '{mode: `RST_BYTE, psc0: `RST_BYTE, psc1: `RST_BYTE,
                 init0: `RST_BYTE, init1: `RST_BYTE, stat: 2'h0, mask: 2'h0,
                 casc: 1'b0, rdata: 8'h00, div: 2'h0, ext_q: 1'b0,
                 line: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign rdata_o                = st_ff.rdata;
  assign timer_output_line_o    = st_ff.line;
  assign timer_output_line_oe_o = (out_sel != 2'b11);
  assign irq_o                  = |(st_ff.stat & st_ff.mask);

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_eoc0;
    ce_i && cif[0].eoc;
  endsequence

  sequence s_read_cnt0;
    ce_i && rd_i && (addr_i == `ADDR_CNT_ZERO);
  endsequence

  sequence s_read_psc;
    ce_i && rd_i && ((addr_i == `ADDR_PSC_ZERO) || (addr_i == `ADDR_PSC_ONE));
  endsequence

  property p_set_wins;
    s_eoc0 |=> st_ff.stat[0];
  endproperty

  property p_single_stop;
    (cif[0].eoc && !st_ff.psc0[`PSC_CONT]) |-> (!cif[0].running && cif[0].count == 8'h00);
  endproperty

  // a single pass end stops the counter, so only the continuous end is followed
  property p_cont_reload;
    ((ce_i && cif[0].eoc && st_ff.psc0[`PSC_CONT]) ##1 (ce_i && !cif[0].load)) |->
      cif[0].running;
  endproperty

  a_stat_set_wins: assert property (p_set_wins)
    else $error("end of count did not set status bit");

  a_single_pass_stop: assert property (p_single_stop)
    else $error("single pass counter kept running");

  a_cont_keeps_run: assert property (
    (cif[0].eoc && st_ff.psc0[`PSC_CONT]) |->
      (cif[0].running && cif[0].count == $past(st_ff.init0)))
    else $error("continuous counter did not reload");

  a_cont_run_after: assert property (p_cont_reload)
    else $error("continuous counter stopped after end");

  a_read_count: assert property (
    s_read_cnt0 |=> (rdata_o == $past(cif[0].count)))
    else $error("count read back wrong");

  a_psc_unread: assert property (s_read_psc |=> (rdata_o == 8'h00))
    else $error("prescaler readable");

  a_mode_readback: assert property (
    (ce_i && wr_i && addr_i == `ADDR_MODE) ##1
    (ce_i && rd_i && addr_i == `ADDR_MODE && !wr_i) |=>
      (rdata_o == ($past(wdata_i, 2) & `MODE_WMASK)))
    else $error("count mode register read back wrong");

  a_cnt_one_write: assert property (
    (ce_i && wr_i && addr_i == `ADDR_CNT_ONE) |=> (st_ff.init1 == $past(wdata_i)))
    else $error("second counter reload value not stored");

  a_gate_blocks: assert property (
    (src_int && in_mode == `IN_GATE && !ext_timer_input_line_i) |-> !cif[1].tick)
    else $error("gate closed but second counter ticked");

  a_retrig_load: assert property (
    (ce_i && src_int && in_mode == `IN_TRIG_RE && ext_rise) |=>
      (cif[1].running && cif[1].count == $past(st_ff.init1)))
    else $error("retrigger did not reload");

  a_div_spacing: assert property (
    (ce_i && div_tick) |=> (!div_tick [*3]))
    else $error("divided clock faster than one in four");

  a_cascade_tick: assert property (
    (!src_int && st_ff.casc && cif[0].eoc) |-> cif[1].tick)
    else $error("cascade did not clock second counter");

  a_line_select: assert property (
    (ce_i && out_sel == `OUT_CNT_ONE) |=> (timer_output_line_o == $past(cif[1].timer_output_pin)))
    else $error("output line not showing second counter");

  a_irq_unmasked: assert property (
    (st_ff.stat[1] && st_ff.mask[1]) |-> irq_o)
    else $error("unmasked status did not raise interrupt");

  // ********************************************************************
  // second counter, bus idle, clock enable, output line and interrupt checks
  // ********************************************************************
  sequence s_eoc1;
    ce_i && cif[1].eoc;
  endsequence

  sequence s_stopped1;
    ce_i && !cif[1].running && !cif[1].load;
  endsequence

  property p_one_set;
    s_eoc1 |=> st_ff.stat[1];
  endproperty

  property p_one_irq;
    (s_eoc1 ##1 st_ff.mask[1]) |-> irq_o;
  endproperty

  a_stat_one_set: assert property (p_one_set)
    else $error("second counter end did not set status bit");

  a_end_raises_irq: assert property (p_one_irq)
    else $error("unmasked end of count did not raise interrupt");

  a_one_single_stop: assert property (
    (cif[1].eoc && !st_ff.psc1[`PSC_CONT]) |->
      (!cif[1].running && cif[1].count == 8'h00))
    else $error("single pass second counter kept running");

  a_one_cont_reload: assert property (
    (cif[1].eoc && st_ff.psc1[`PSC_CONT]) |->
      (cif[1].running && cif[1].count == $past(st_ff.init1)))
    else $error("continuous second counter did not reload");

  a_stop_holds: assert property (s_stopped1 |=> $stable(cif[1].count))
    else $error("stopped second counter changed");

  a_idle_rdata: assert property ((ce_i && !rd_i) |=> (rdata_o == 8'h00))
    else $error("read data not cleared after its cycle");

  a_freeze_counts: assert property (
    !ce_i |=> ($stable(cif[0].count) && $stable(cif[1].count)))
    else $error("counts moved while clock enable low");

  a_once_no_reload: assert property (
    (ce_i && in_mode == `IN_TRIG_ONCE && cif[1].running && !wr_mode) |->
      !cif[1].load)
    else $error("running counter retriggered in single trigger mode");

  a_ext_clock_tick: assert property (
    (!src_int && !st_ff.casc && ext_rise) |-> cif[1].tick)
    else $error("external edge did not clock second counter");

  a_int_clock_tick: assert property (
    (src_int && in_mode != `IN_GATE) |-> (cif[1].tick == div_tick))
    else $error("second counter not on divided clock");

  a_line_zero: assert property (
    (ce_i && out_sel == `OUT_CNT_ZERO) |=>
      (timer_output_line_o == $past(cif[0].timer_output_pin)))
    else $error("output line not showing first counter");

  a_irq_masked: assert property ((st_ff.mask == 2'h0) |-> !irq_o)
    else $error("interrupt raised with all sources masked");
endmodule

/* File: verif/ext_line_source.sv */
// stand-in for the source wired to the external timer input line
// assumes the bench calls its tasks from one process, in step with mclk_i
`timescale 1ns/1ps
module ext_line_source
(
  // clock
  input  wire logic  mclk_i,
  // driven line
  output logic       line_o
);
  // ******************************************************************
  // stimulus tasks
  // ******************************************************************
  // the line starts low and each pulse returns it low, as an idle clock source would
  initial line_o = 1'b0;

  // n rising edges, each high for hi cycles; a long hi plays a slow source
  task automatic pulse(input int n, input int hi);
    repeat (n)
    begin
      @(posedge mclk_i);
      line_o <= 1'b1;
      repeat (hi) @(posedge mclk_i);
      line_o <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
  endtask

  task automatic hold(input logic v);
    @(posedge mclk_i);
    line_o <= v;
  endtask
endmodule

/* File: verif/test_dual_timer.sv */
// self-checking bench for the dual counter/timer over its register port
// assumes the timer package and the external line source are compiled first
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module test_dual_timer;
  import dual_timer_pkg::*;
  logic        mclk_i;
  logic        sys_rst_i;
  logic        ce_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic [7:0]  rdata_o;
  logic [7:0]  rd_v;
  logic        line_o;
  logic        oe_o;
  logic        irq_o;
  logic        ext_line;
  int          errors;
  int          num_checks;
  int          tr;
  logic [1:0]  sel_tab [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  int          tr_tab [4] = '{4, 8, 32, 0};

  dual_timer dual_timer_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_timer_input_line_i(ext_line), .timer_output_line_o(line_o),
    .timer_output_line_oe_o(oe_o), .irq_o(irq_o));
  ext_line_source ext_line_source_inst (.mclk_i(mclk_i), .line_o(ext_line));

  // ******************************************************************
  // bus and compare tasks
  // ******************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask

  // write then read with no idle cycle between the two strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk8(rd_v, exp, "read");
  endtask

  // bounded wait for the interrupt line, then it must be high
  task automatic wait_irq(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk_i);
      #1;
      if (irq_o === 1'b1)
        break;
    end
    chk1(irq_o, 1'b1, "irq");
  endtask

  task automatic count_tr(input int n);
    logic p;
    tr = 0;
    @(posedge mclk_i);
    #1;
    p = line_o;
    repeat (n)
    begin
      @(posedge mclk_i);
      #1;
      if (line_o !== p)
        tr++;
      p = line_o;
    end
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ******************************************************************
  // clock, watchdog, tests
  // ******************************************************************
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    {wr_i, rd_i, addr_i, wdata_i} = '0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk1(oe_o, 1'b1, "oe rst");
    rchk(`ADDR_MODE, 8'h00);
    rchk(8'h10, 8'h00);
    wr(8'h10, 8'hff);
    wr_rd(`ADDR_MODE, 8'hb7);
    chk8(rd_v, 8'hb2, "mode");
    wr(`ADDR_MODE, 8'hc0);
    #1;
    chk1(oe_o, 1'b0, "oe off");
    endt("mode");
    wr(`ADDR_CNT_ONE, 8'h55);
    wr(`ADDR_MODE, 8'h04);
    rchk(`ADDR_CNT_ONE, 8'h55);
    rchk(`ADDR_CNT_ONE, 8'h55);
    wr(`ADDR_PSC_ONE, 8'h06);
    rchk(`ADDR_PSC_ONE, 8'h00);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(`ADDR_MASK, 8'h03);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rchk(`ADDR_MASK, 8'h00);
    endt("access");
    // single pass on counter zero stops at end and raises its source
    wr(`ADDR_MASK, 8'h01);
    wr(`ADDR_PSC_ZERO, 8'h04);
    wr(`ADDR_CNT_ZERO, 8'h02);
    wr(`ADDR_MODE, 8'h03);
    wait_irq(40);
    repeat (20) @(posedge mclk_i);
    rchk(`ADDR_CNT_ZERO, 8'h00);
    rchk(`ADDR_STAT, 8'h01);
    wr(`ADDR_STAT, 8'h01);
    #1;
    chk1(irq_o, 1'b0, "irq clear");
    // continuous mode, masked first, must come round again
    wr(`ADDR_MASK, 8'h00);
    wr(`ADDR_PSC_ZERO, 8'h05);
    wr(`ADDR_CNT_ZERO, 8'h03);
    wr(`ADDR_MODE, 8'h03);
    repeat (30) @(posedge mclk_i);
    #1;
    chk1(irq_o, 1'b0, "masked");
    rchk(`ADDR_STAT, 8'h01);
    wr(`ADDR_MASK, 8'h01);
    wr(`ADDR_STAT, 8'h01);
    wait_irq(30);
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_STAT, 8'h03);
    endt("counter zero");
    // counter one on the internal divided clock
    wr(`ADDR_MASK, 8'h02);
    wr(`ADDR_CNT_ONE, 8'h03);
    wr(`ADDR_MODE, 8'h0c);
    wait_irq(40);
    wr(`ADDR_STAT, 8'h02);
    // counter one on external edges only
    wr(`ADDR_PSC_ONE, 8'h04);
    wr(`ADDR_MODE, 8'h0c);
    ext_line_source_inst.pulse(2, 3);
    repeat (4) @(posedge mclk_i);
    rchk(`ADDR_CNT_ONE, 8'h01);
    rchk(`ADDR_STAT, 8'h00);
    ext_line_source_inst.pulse(1, 6);
    repeat (4) @(posedge mclk_i);
    rchk(`ADDR_STAT, 8'h02);
    wr(`ADDR_STAT, 8'h02);
    // gate mode holds the count while the line is low
    wr(`ADDR_PSC_ONE, 8'h06);
    wr(`ADDR_CNT_ONE, 8'h04);
    wr(`ADDR_MODE, 8'h1c);
    repeat (40) @(posedge mclk_i);
    rchk(`ADDR_CNT_ONE, 8'h04);
    ext_line_source_inst.hold(1'b1);
    wait_irq(40);
    ext_line_source_inst.hold(1'b0);
    wr(`ADDR_STAT, 8'h02);
    // second trigger ignored, then honoured in the retrigger mode
    wr(`ADDR_CNT_ONE, 8'h10);
    wr(`ADDR_MODE, 8'h28);
    ext_line_source_inst.pulse(1, 3);
    repeat (40) @(posedge mclk_i);
    ext_line_source_inst.pulse(1, 3);
    repeat (8) @(posedge mclk_i);
    rd(`ADDR_CNT_ONE);
    chk1(rd_v < 8'h0b, 1'b1, "no retrigger");
    repeat (40) @(posedge mclk_i);
    wr(`ADDR_MODE, 8'h38);
    ext_line_source_inst.pulse(1, 3);
    repeat (40) @(posedge mclk_i);
    ext_line_source_inst.pulse(1, 3);
    repeat (8) @(posedge mclk_i);
    rd(`ADDR_CNT_ONE);
    chk1(rd_v > 8'h0b, 1'b1, "retrigger");
    repeat (80) @(posedge mclk_i);
    endt("counter one");
    // cascade: two ends of counter zero end counter one
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_STAT, 8'h03);
    wr(`ADDR_CASC, 8'h01);
    wr(`ADDR_PSC_ONE, 8'h04);
    wr(`ADDR_CNT_ONE, 8'h02);
    wr(`ADDR_CNT_ZERO, 8'h02);
    wr(`ADDR_MODE, 8'h0f);
    wait_irq(60);
    wr(`ADDR_CASC, 8'h00);
    endt("cascade");
    // output line: each select gives its own toggle rate
    wr(`ADDR_PSC_ONE, 8'h07);
    wr(`ADDR_CNT_ONE, 8'h01);
    wr(`ADDR_MODE, 8'h0f);
    for (int k = 0; k < 4; k++)
    begin
      wr({sel_tab[k], 6'h0a}, 8'h00);
      wr(`ADDR_MODE, {sel_tab[k], 6'h0a});
      repeat (4) @(posedge mclk_i);
      count_tr(32);
      chk8(8'(tr), 8'(tr_tab[k]), "toggles");
      chk1(oe_o, sel_tab[k] != 2'b11, "oe");
    end
    endt("output");
    finish_test();
  end
endmodule
